// >>> vad_map.svh
// Constants of the voice activity detector: sizes, thresholds and offsets.
`ifndef VAD_MAP_SVH
`define VAD_MAP_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define VAD_NLAG      13
`define VAD_NLSF      10
`define VAD_NSMP      80
`define VAD_NI        32
`define VAD_N0        128
`define VAD_SEG_LEN   8
`define VAD_NSEG      16
`define VAD_INIT_LAST 11

// ****************************************************************
// Energies in dB with eight fraction bits
// ****************************************************************
`define VAD_E15DB     32'sh0000_0F00
`define VAD_LOGN      32'sh0000_17CD
`define VAD_DB_OCT    64'h0000_0000_0000_0303
`define VAD_EMAX      32'sh7FFF_FFFF
`define VAD_T1        32'sh0000_2800
`define VAD_T2        32'sh0000_2C00
`define VAD_T6        32'sh0000_0180
`define VAD_K0        32'sh0000_0000
`define VAD_K1        (-32'sh0000_0200)
`define VAD_K2        (-32'sh0000_0200)
`define VAD_K3        (-32'sh0000_0400)
`define VAD_K4        (-32'sh0000_0400)
`define VAD_K5        (-32'sh0000_0600)

// ****************************************************************
// Rates and averaging
// ****************************************************************
`define VAD_ZC_STEP   32'sh0000_0199
`define VAD_AR_SHIFT  3

`endif

// >>> vad_pkg.sv
// Types shared by the voice activity detector modules.
`default_nettype none
package vad_pkg;

  typedef logic signed [31:0] vad_word_t;

  typedef enum logic [2:0] {
    ST_COLLECT = 3'b000,
    ST_LOG     = 3'b001,
    ST_INIT    = 3'b010,
    ST_SCAN    = 3'b011,
    ST_DEC     = 3'b100,
    ST_UPD     = 3'b101
  } vad_state_e;

endpackage
`default_nettype wire

// >>> vad_mem.sv
// Small memory holding the energy minima of past segments.
`timescale 1ns/1ns
`default_nettype none
module vad_mem #(
  parameter int W  = 32,
  parameter int D  = 16,
  parameter int AW = $clog2(D)
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          srst,
  // Write side.
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // Read side, one cycle of latency.
  input  wire logic [AW-1:0] rd_addr,
  output logic [W-1:0]       rd_data_ff
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem[rd_addr];
    end
  end
endmodule // vad_mem
`default_nettype wire

// >>> vad_log.sv
// Registered ten-times-log10 of an unsigned value, in dB with eight fraction bits.
`timescale 1ns/1ns
`default_nettype none
`include "vad_map.svh"
module vad_log #(
  parameter int W = 40
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         srst,
  // Operand and result.
  input  wire logic [W-1:0] x,
  output logic signed [31:0] db_ff
);
  // Octave from the leading one, eight bits of mantissa as a linear fraction.
  function automatic logic signed [31:0] log_db(input logic [W-1:0] v);
    logic [5:0]  msb;
    logic [W-1:0] norm;
    logic [31:0] l2;
    msb = '0;
    for (int i = 0; i < W; i++) begin
      if (v[i]) begin
        msb = 6'(i);
      end
    end
    norm = v << (W - 1 - int'(msb));
    l2 = {18'h0_0000, msb, norm[W-2 -: 8]};
    return 32'((64'(l2) * `VAD_DB_OCT) >> 8);
  endfunction

  always_ff @(posedge clk) begin
    if (srst) begin
      db_ff <= '0;
    end else begin
      db_ff <= log_db(x);
    end
  end
endmodule // vad_log
`default_nettype wire

// >>> vad_top.sv
// Voice activity detector: features, noise averages and the initial decision.
// Contract
// [R1] Frames in order; index counts up from zero.
// [R2] Init frames: accumulate; activity is energy above 15dB.
// [R3] At init count, seed background energy averages once.
// [R4] Front end supplies lags zero to twelve.
// [R5] Ten spectral frequencies per frame from prediction.
// [R6] Full-band energy: 10log10 of R0 over 240.
// [R7] Low-band energy: filter quadratic form over 240.
// [R8] Zero-crossing rate over 80 samples, normalised.
// [R9] Init spectral and zero-crossing averages are means.
// [R10] Init averages use only frames above 15dB.
// [R11] Background energies: mean plus offset by range.
// [R12] Long-term minimum from stored segment minima.
// [R13] Distortion: sum of squared frequency differences.
// [R14] Full-band difference: background minus current.
// [R15] Low-band difference: current minus background.
// [R16] Zero-crossing difference: current minus background.
// [R17] Flag zero inside inactive region, else one.
// [R18] Boundaries one to seven on distortion, full-band.
// [R19] Boundaries eight to fourteen on low-band.
// [R20] Update averages only when energy test passes.
// [R21] One decision per 10 ms frame.
// [R22] Output bit: one voice, zero silence.
// [R23] One-cycle valid strobe; output held between frames.
`timescale 1ns/1ns
`default_nettype none
`include "vad_map.svh"
module vad_top
  import vad_pkg::*;
#(
  parameter int NI = `VAD_NI,
  parameter int N0 = `VAD_N0
) (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               srst,
  // Autocorrelation stream, one lag a beat.
  input  wire logic               acor_valid,
  input  wire logic [3:0]         acor_lag,
  input  wire logic signed [31:0] acor_data,
  // Pre-processed samples.
  input  wire logic               smp_valid,
  input  wire logic signed [15:0] smp_data,
  // Spectral frequencies of the frame.
  input  wire logic               lsf_valid,
  input  wire logic [3:0]         lsf_idx,
  input  wire logic signed [15:0] lsf_data,
  // Frame close.
  input  wire logic               frame_end,
  // Decision.
  output logic                    activity_ff,
  output logic                    activity_valid_ff,
  output logic [15:0]             frame_index_ff,
  output logic                    busy_ff
);
  localparam int NL = `VAD_NLSF;

  // ****************************************************************
  // Constant tables
  // ****************************************************************
  localparam logic signed [15:0] LB_GAIN [`VAD_NLAG] = '{
    16'sh2000, 16'sh3800, 16'sh2C00, 16'sh1C00, 16'sh0C00, 16'sh0200, 16'sh0000,
    16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000};
  localparam vad_word_t A_TAB [14] = '{
    23488, -30504, -32768, 26214, 0, 28160, 0,
    16384, -19065, 0, 22400, 30427, -24576, 23406};
  localparam vad_word_t B_TAB [14] = '{
    28521, 19446, -32768, -19661, -30802, -19661, 30199,
    -22938, -31576, -17367, -27034, 29959, -29491, -28087};

  function automatic vad_word_t lin(input int k, input vad_word_t x);
    logic signed [63:0] p;
    p = 64'(A_TAB[k]) * 64'(x);
    return 32'(p >>> 15) + B_TAB[k];
  endfunction

  function automatic vad_word_t wmin(input vad_word_t a, input vad_word_t b);
    return (a < b) ? a : b;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  vad_state_e               state_ff;
  logic [4:0]               idx_ff;
  logic signed [31:0]       r0_in_ff, r0_ff;
  logic signed [63:0]       lb_acc_ff;
  logic [39:0]              lb_ff;
  logic [6:0]               zc_cnt_ff;
  logic                     sgn_prev_ff;
  vad_word_t                zc_ff, zc_bg_ff, ef_ff, el_ff, ef_bg_ff, el_bg_ff;
  vad_word_t                ds_ff, emin_ff, seg_min_ff;
  logic signed [15:0]       lsf_in_ff [NL];
  logic signed [15:0]       lsf_cur_ff [NL];
  logic signed [15:0]       lsf_bg_ff [NL];
  logic signed [39:0]       lsf_sum_ff [NL];
  logic signed [39:0]       zc_sum_ff, en_sum_ff;
  logic [5:0]               hot_cnt_ff;
  logic [2:0]               seg_pos_ff;
  logic [3:0]               seg_wr_ff;
  logic [4:0]               seg_cnt_ff;
  logic                     ivd_ff;
  logic                     take_frame, hot, init_frame, mem_wr;
  logic [3:0]               idx_l;
  logic signed [39:0]       div_num, quot;
  logic [5:0]               div_den;
  logic signed [63:0]       lb_sh;
  logic [39:0]              r0_x;
  vad_word_t                ef_db, el_db, def, del, dzc, en_mean, mem_rd, seg_new;
  vad_word_t                nxt_ef_bg;
  logic signed [16:0]       lsf_d;
  logic [13:0]              bound;

  assign take_frame = frame_end && (state_ff == ST_COLLECT);
  assign hot        = ef_ff > `VAD_E15DB;
  assign init_frame = frame_index_ff < 16'(NI);
  assign idx_l      = (idx_ff < 5'(NL)) ? idx_ff[3:0] : 4'h0;
  assign r0_x       = (r0_ff > 0) ? {8'h00, r0_ff} : 40'h00_0000_0001;
  assign lb_sh      = lb_acc_ff >>> 15;

  // ****************************************************************
  // Feature capture
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      r0_in_ff  <= '0;
      r0_ff     <= '0;
      lb_acc_ff <= '0;
      lb_ff     <= 40'h00_0000_0001;
    end else if (take_frame) begin
      r0_ff     <= r0_in_ff;
      lb_ff     <= (lb_sh > 0) ? lb_sh[39:0] : 40'h00_0000_0001;
      lb_acc_ff <= '0;
    end else if (acor_valid && acor_lag < 4'(`VAD_NLAG)) begin // R4
      if (acor_lag == 4'h0) begin
        r0_in_ff <= acor_data;
      end
      lb_acc_ff <= lb_acc_ff + 64'(acor_data) * 64'(LB_GAIN[acor_lag]); // R7
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      zc_cnt_ff   <= '0;
      sgn_prev_ff <= 1'b0;
      zc_ff       <= '0;
    end else begin
      if (smp_valid) begin
        sgn_prev_ff <= smp_data[15];
      end
      if (take_frame) begin
        zc_ff     <= 32'(zc_cnt_ff) * `VAD_ZC_STEP; // R8
        zc_cnt_ff <= '0;
      end else if (smp_valid && smp_data[15] != sgn_prev_ff &&
                   zc_cnt_ff < 7'(`VAD_NSMP)) begin
        zc_cnt_ff <= zc_cnt_ff + 7'h01; // R8
      end
    end
  end

  // Spectral frequencies are held per frame so the next frame may stream in.
  always_ff @(posedge clk) begin
    if (srst) begin
      lsf_in_ff  <= '{default: '0};
      lsf_cur_ff <= '{default: '0};
    end else begin
      if (lsf_valid && lsf_idx < 4'(NL)) begin
        lsf_in_ff[lsf_idx] <= lsf_data; // R5
      end
      if (take_frame) begin
        lsf_cur_ff <= lsf_in_ff;
      end
    end
  end

  vad_log #(.W(40)) u_log_full (
    .clk   (clk),
    .srst  (srst),
    .x     (r0_x),
    .db_ff (ef_db)
  );

  vad_log #(.W(40)) u_log_low (
    .clk   (clk),
    .srst  (srst),
    .x     (lb_ff),
    .db_ff (el_db)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_COLLECT;
      idx_ff   <= '0;
      busy_ff  <= 1'b0;
    end else begin
      busy_ff <= (state_ff != ST_UPD) && (state_ff != ST_COLLECT || take_frame);
      unique case (state_ff)
        ST_COLLECT: begin
          idx_ff <= '0;
          if (take_frame) begin
            state_ff <= ST_LOG; // R21
          end
        end
        ST_LOG: begin
          if (idx_ff == 5'h01) begin
            idx_ff   <= '0;
            state_ff <= (frame_index_ff <= 16'(NI)) ? ST_INIT : ST_SCAN;
          end else begin
            idx_ff <= idx_ff + 5'h01;
          end
        end
        ST_INIT: begin
          if (idx_ff == 5'(`VAD_INIT_LAST)) begin
            idx_ff   <= '0;
            state_ff <= init_frame ? ST_UPD : ST_SCAN;
          end else begin
            idx_ff <= idx_ff + 5'h01;
          end
        end
        ST_SCAN: begin
          if (idx_ff == 5'(`VAD_NSEG)) begin
            state_ff <= ST_DEC;
          end else begin
            idx_ff <= idx_ff + 5'h01;
          end
        end
        ST_DEC: state_ff <= ST_UPD;
        ST_UPD: state_ff <= ST_COLLECT;
        default: state_ff <= ST_COLLECT;
      endcase
    end
  end

  // ****************************************************************
  // Initial averages
  // ****************************************************************
  always_comb begin
    div_num = (idx_ff < 5'(NL)) ? lsf_sum_ff[idx_l] :
              (idx_ff == 5'h0A) ? zc_sum_ff : en_sum_ff;
    div_den = (hot_cnt_ff == 6'h00) ? 6'h01 : hot_cnt_ff;
    quot    = div_num / $signed({34'h0, div_den});
    en_mean = 32'(quot);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lsf_sum_ff <= '{default: '0};
      zc_sum_ff  <= '0;
      en_sum_ff  <= '0;
      hot_cnt_ff <= '0;
    end else if (state_ff == ST_INIT && init_frame && hot) begin // R2 R10
      if (idx_ff < 5'(NL)) begin
        lsf_sum_ff[idx_l] <= lsf_sum_ff[idx_l] + 40'(lsf_cur_ff[idx_l]);
      end else if (idx_ff == 5'h0A) begin
        zc_sum_ff <= zc_sum_ff + 40'(zc_ff);
      end else begin
        en_sum_ff  <= en_sum_ff + 40'(ef_ff);
        hot_cnt_ff <= hot_cnt_ff + 6'h01;
      end
    end
  end

  // ****************************************************************
  // Frame energies and background averages
  // ****************************************************************
  always_comb begin
    nxt_ef_bg = ef_bg_ff + ((ef_ff - ef_bg_ff) >>> `VAD_AR_SHIFT);
    if (frame_index_ff > 16'(N0) && nxt_ef_bg < emin_ff) begin
      nxt_ef_bg = emin_ff; // R12
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ef_ff     <= '0;
      el_ff     <= '0;
      ef_bg_ff  <= '0;
      el_bg_ff  <= '0;
      zc_bg_ff  <= '0;
      lsf_bg_ff <= '{default: '0};
    end else if (state_ff == ST_LOG && idx_ff == 5'h01) begin
      ef_ff <= ef_db - `VAD_LOGN; // R6
      el_ff <= el_db - `VAD_LOGN; // R7
    end else if (state_ff == ST_INIT && !init_frame) begin // R3
      if (idx_ff < 5'(NL)) begin
        lsf_bg_ff[idx_l] <= 16'(quot); // R9
      end else if (idx_ff == 5'h0A) begin
        zc_bg_ff <= en_mean; // R9
      end else if (en_mean <= `VAD_T1) begin // R11
        ef_bg_ff <= en_mean + `VAD_K0;
        el_bg_ff <= en_mean + `VAD_K1;
      end else if (en_mean < `VAD_T2) begin
        ef_bg_ff <= en_mean + `VAD_K2;
        el_bg_ff <= en_mean + `VAD_K3;
      end else begin
        ef_bg_ff <= en_mean + `VAD_K4;
        el_bg_ff <= en_mean + `VAD_K5;
      end
    end else if (state_ff == ST_UPD && frame_index_ff > 16'(NI) &&
                 ef_ff < ef_bg_ff + `VAD_T6) begin // R20
      ef_bg_ff <= nxt_ef_bg;
      el_bg_ff <= el_bg_ff + ((el_ff - el_bg_ff) >>> `VAD_AR_SHIFT);
      zc_bg_ff <= zc_bg_ff + ((zc_ff - zc_bg_ff) >>> `VAD_AR_SHIFT);
      for (int i = 0; i < NL; i++) begin
        lsf_bg_ff[i] <= lsf_bg_ff[i] + ((lsf_cur_ff[i] - lsf_bg_ff[i]) >>> `VAD_AR_SHIFT);
      end
    end
  end

  // ****************************************************************
  // Long-term minimum
  // ****************************************************************
  assign seg_new = (seg_pos_ff == 3'h0) ? ef_ff : wmin(seg_min_ff, ef_ff);
  assign mem_wr  = (state_ff == ST_UPD) && (seg_pos_ff == 3'(`VAD_SEG_LEN - 1));

  vad_mem #(.W(32), .D(`VAD_NSEG)) u_seg_min (
    .clk        (clk),
    .srst       (srst),
    .wr_en      (mem_wr),
    .wr_addr    (seg_wr_ff),
    .wr_data    (seg_new),
    .rd_addr    (idx_ff[3:0]),
    .rd_data_ff (mem_rd)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      seg_min_ff <= `VAD_EMAX;
      seg_pos_ff <= '0;
      seg_wr_ff  <= '0;
      seg_cnt_ff <= '0;
    end else if (state_ff == ST_UPD) begin // R12
      seg_min_ff <= seg_new;
      seg_pos_ff <= seg_pos_ff + 3'h1;
      if (mem_wr) begin
        seg_wr_ff <= seg_wr_ff + 4'h1;
        if (seg_cnt_ff != 5'(`VAD_NSEG)) begin
          seg_cnt_ff <= seg_cnt_ff + 5'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Distortion and minimum scan
  // ****************************************************************
  assign lsf_d = 17'(lsf_cur_ff[idx_l]) - 17'(lsf_bg_ff[idx_l]);

  always_ff @(posedge clk) begin
    if (srst) begin
      ds_ff   <= '0;
      emin_ff <= `VAD_EMAX;
    end else if (state_ff == ST_SCAN) begin
      if (idx_ff == 5'h00) begin
        ds_ff   <= 32'((34'(lsf_d) * 34'(lsf_d)) >>> 15); // R13
        emin_ff <= (seg_pos_ff == 3'h0) ? `VAD_EMAX : seg_min_ff;
      end else begin
        if (idx_ff < 5'(NL)) begin
          ds_ff <= ds_ff + 32'((34'(lsf_d) * 34'(lsf_d)) >>> 15); // R13
        end
        if (idx_ff <= seg_cnt_ff) begin
          emin_ff <= wmin(emin_ff, mem_rd); // R12
        end
      end
    end
  end

  // ****************************************************************
  // Boundary decision
  // ****************************************************************
  always_comb begin
    def = ef_bg_ff - ef_ff; // R14
    del = el_ff - el_bg_ff; // R15
    dzc = zc_ff - zc_bg_ff; // R16
    bound[0]  = ds_ff > lin(0, dzc); // R18
    bound[1]  = ds_ff > lin(1, dzc);
    bound[2]  = def < lin(2, dzc);
    bound[3]  = def < lin(3, dzc);
    bound[4]  = def < B_TAB[4];
    bound[5]  = def < lin(5, ds_ff);
    bound[6]  = ds_ff > B_TAB[6];
    bound[7]  = del < lin(7, dzc); // R19
    bound[8]  = del < lin(8, dzc);
    bound[9]  = del < B_TAB[9];
    bound[10] = del < lin(10, ds_ff);
    bound[11] = del > lin(11, def);
    bound[12] = del < lin(12, def);
    bound[13] = del < lin(13, def);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ivd_ff <= 1'b0;
    end else if (state_ff == ST_DEC) begin
      ivd_ff <= |bound; // R17
    end
  end

  // ****************************************************************
  // Output and frame index
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      activity_ff       <= 1'b0;
      activity_valid_ff <= 1'b0;
      frame_index_ff    <= '0;
    end else begin
      activity_valid_ff <= (state_ff == ST_UPD); // R23
      if (state_ff == ST_UPD) begin
        activity_ff <= init_frame ? hot : ivd_ff; // R2 R22
        if (frame_index_ff != 16'hFFFF) begin
          frame_index_ff <= frame_index_ff + 16'h0001; // R1
        end
      end
    end
  end
endmodule // vad_top
`default_nettype wire

// >>> vad_top_sva.sv
// Checker of the detector's frame timing, strobe and index.
`timescale 1ns/1ns
`default_nettype none
module vad_top_sva #(
  parameter int NI = 32,
  parameter int N0 = 128
) (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        srst,
  // Frame close and decision.
  input wire logic        frame_end,
  input wire logic        activity_ff,
  input wire logic        activity_valid_ff,
  input wire logic [15:0] frame_index_ff,
  input wire logic        busy_ff
);
  localparam logic [15:0] NI16 = 16'(NI);
  logic start;
  assign start = frame_end && !busy_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_valid_pulse;
    activity_valid_ff |=> !activity_valid_ff;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("strobe too long");
  property p_hold;
    !activity_valid_ff && !$past(srst) |-> $stable(activity_ff) && $stable(frame_index_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("decision moved without strobe");
  property p_idx_step;
    activity_valid_ff |-> frame_index_ff == (($past(frame_index_ff) == 16'hFFFF) ?
      16'hFFFF : $past(frame_index_ff) + 16'h0001);
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("index did not step by one");
  property p_busy_on;
    start |=> busy_ff;
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy not raised");
  property p_busy_off;
    activity_valid_ff |-> !busy_ff && $past(busy_ff);
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("strobe without busy frame");
  property p_lat_init;
    start && frame_index_ff < NI16 |-> ##16 activity_valid_ff;
  endproperty
  a_lat_init: assert property (p_lat_init) else $error("init frame latency");
  property p_lat_seed;
    start && frame_index_ff == NI16 |-> ##34 activity_valid_ff;
  endproperty
  a_lat_seed: assert property (p_lat_seed) else $error("seed frame latency");
  property p_lat_run;
    start && frame_index_ff > NI16 |-> ##22 activity_valid_ff;
  endproperty
  a_lat_run: assert property (p_lat_run) else $error("running frame latency");
endmodule // vad_top_sva
bind vad_top vad_top_sva #(.NI(NI), .N0(N0)) i_vad_top_sva (
  .clk(clk), .srst(srst), .frame_end(frame_end), .activity_ff(activity_ff),
  .activity_valid_ff(activity_valid_ff), .frame_index_ff(frame_index_ff), .busy_ff(busy_ff));
`default_nettype wire

// >>> vad_fe_model.sv
// Front-end model feeding one frame of lags, samples and frequencies.
`timescale 1ns/1ns
`default_nettype none
module vad_fe_model (
  // Clock and control.
  input  wire logic               clk,
  input  wire logic               go,
  input  wire logic signed [31:0] r0,
  input  wire logic               extra_end,
  input  wire logic               lsf_neg,
  // Streams to the detector.
  output logic                    acor_valid,
  output logic [3:0]              acor_lag,
  output logic signed [31:0]      acor_data,
  output logic                    smp_valid,
  output logic signed [15:0]      smp_data,
  output logic                    lsf_valid,
  output logic [3:0]              lsf_idx,
  output logic signed [15:0]      lsf_data,
  output wire logic               frame_end
);
  logic end_ff;
  int   i;
  assign frame_end = end_ff | extra_end;
  initial begin
    {acor_valid, smp_valid, lsf_valid, end_ff} = 4'h0;
    acor_lag = 4'h0;
    acor_data = 32'sh0;
    smp_data = 16'sh0;
    lsf_idx = 4'h0;
    lsf_data = 16'sh0;
    forever begin
      @(posedge clk);
      if (go) begin
        for (i = 0; i < 13; i++) begin
          acor_valid <= 1'b1;
          acor_lag   <= 4'(i);
          acor_data  <= r0 >>> i;
          @(posedge clk);
        end
        acor_valid <= 1'b0;
        acor_data  <= ~acor_data;
        for (i = 0; i < 80; i++) begin
          smp_valid <= 1'b1;
          smp_data  <= i[0] ? -16'sh0064 : 16'sh0064;
          @(posedge clk);
        end
        smp_valid <= 1'b0;
        smp_data  <= ~smp_data;
        for (i = 0; i < 10; i++) begin
          lsf_valid <= 1'b1;
          lsf_idx   <= 4'(i);
          // A set lsf_neg pulls every frequency far from its background value.
          lsf_data  <= lsf_neg ? 16'sh8000 : 16'(i * 1024 + 1024);
          @(posedge clk);
        end
        lsf_valid <= 1'b0;
        lsf_data  <= ~lsf_data;
        end_ff    <= 1'b1;
        @(posedge clk);
        end_ff    <= 1'b0;
      end
    end
  end
endmodule // vad_fe_model
`default_nettype wire

// >>> tb_voice_activity_detector.sv
// Self-checking bench of the voice activity detector.
`timescale 1ns/1ns
`default_nettype none
module tb_voice_activity_detector;
  localparam int NI = 4;
  localparam int N0 = 16;
  localparam logic signed [31:0] LOUD  = 32'sh0003_A980;
  localparam logic signed [31:0] QUIET = 32'sh0000_00F0;
  localparam logic signed [31:0] HUGE  = 32'sh7FFF_FFFF;
  logic clk, srst, go, extra_end, lsf_neg;
  logic signed [31:0] r0, acor_data;
  logic signed [15:0] smp_data, lsf_data;
  logic [3:0] acor_lag, lsf_idx;
  logic acor_valid, smp_valid, lsf_valid, frame_end, activity, act_valid, busy;
  logic [15:0] frame_index;
  int mismatches, comparisons, cycles;

  vad_top #(.NI(NI), .N0(N0)) i_vad_top (
    .clk(clk), .srst(srst), .acor_valid(acor_valid), .acor_lag(acor_lag),
    .acor_data(acor_data), .smp_valid(smp_valid), .smp_data(smp_data),
    .lsf_valid(lsf_valid), .lsf_idx(lsf_idx), .lsf_data(lsf_data), .frame_end(frame_end),
    .activity_ff(activity), .activity_valid_ff(act_valid), .frame_index_ff(frame_index),
    .busy_ff(busy));
  vad_fe_model i_vad_fe_model (
    .clk(clk), .go(go), .r0(r0), .extra_end(extra_end), .lsf_neg(lsf_neg),
    .acor_valid(acor_valid),
    .acor_lag(acor_lag), .acor_data(acor_data), .smp_valid(smp_valid), .smp_data(smp_data),
    .lsf_valid(lsf_valid), .lsf_idx(lsf_idx), .lsf_data(lsf_data), .frame_end(frame_end));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("counts comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Sends one frame, times the decision and watches for a stray second one.
  task automatic run_frame(input logic signed [31:0] e, input int lat, input logic exp_act,
                           input logic chk_act, input logic poke);
    int n;
    int extra;
    logic [15:0] idx0;
    idx0 = frame_index;
    r0 <= e;
    go <= 1'b1;
    @(posedge clk);
    #1;
    go <= 1'b0;
    n = 0;
    while (frame_end !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    // Cycle zero is the one in which frame_end stands.
    n = 0;
    while (act_valid !== 1'b1 && n < 300) begin
      @(posedge clk);
      extra_end <= poke && n == 4;
      #1;
      n++;
    end
    extra_end <= 1'b0;
    check("latency", 32'(n), 32'(lat));
    if (chk_act) check("activity", {31'h0, activity}, {31'h0, exp_act});
    check("index", {16'h0, frame_index}, {16'h0, idx0 + 16'h0001});
    extra = 0;
    repeat (30) begin
      @(posedge clk);
      #1;
      if (act_valid !== 1'b0) extra++;
    end
    check("extra decisions", 32'(extra), 32'h0);
  endtask

  task automatic t_reset;
    check("reset outputs", {29'h0, activity, act_valid, busy}, 32'h0);
    check("reset index", {16'h0, frame_index}, 32'h0);
    $display("done reset");
  endtask

  task automatic t_init;
    run_frame(LOUD, 16, 1'b1, 1'b1, 1'b0);
    run_frame(QUIET, 16, 1'b0, 1'b1, 1'b1);
    run_frame(LOUD, 16, 1'b1, 1'b1, 1'b0);
    run_frame(QUIET, 16, 1'b0, 1'b1, 1'b0);
    $display("done init");
  endtask

  task automatic t_seed;
    run_frame(LOUD, 34, 1'b0, 1'b1, 1'b0);
    $display("done seed");
  endtask

  task automatic t_run;
    // Loud frames with background spectra stay inactive; distorted spectra are voice.
    repeat (7) begin
      lsf_neg <= 1'b0;
      run_frame(HUGE, 22, 1'b0, 1'b1, 1'b0);
      lsf_neg <= 1'b1;
      run_frame(HUGE, 22, 1'b1, 1'b1, 1'b0);
    end
    lsf_neg <= 1'b0;
    run_frame(HUGE, 22, 1'b0, 1'b1, 1'b1);
    $display("done run");
  endtask

  task automatic t_rerun;
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check("index after reset", {16'h0, frame_index}, 32'h0);
    run_frame(QUIET, 16, 1'b0, 1'b1, 1'b0);
    run_frame(LOUD, 16, 1'b1, 1'b1, 1'b0);
    $display("done rerun");
  endtask

  initial begin
    srst = 1'b1;
    go = 1'b0;
    extra_end = 1'b0;
    lsf_neg = 1'b0;
    r0 = 32'sh0;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_init();
    t_seed();
    t_run();
    t_rerun();
    give_verdict();
  end
endmodule // tb_voice_activity_detector
`default_nettype wire
